// ===== verilog/codec_ctrl_pkg.sv
// Shared constants and types for the codec serial control block
package codec_ctrl_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int REG_COUNT = 6;
  localparam logic [2:0] REG_PORT_MODE = 3'h0;
  localparam logic [2:0] REG_CLOCK_RATE = 3'h1;
  localparam logic [2:0] REG_POWER = 3'h2;
  localparam logic [2:0] REG_GAIN = 3'h3;
  localparam logic [2:0] REG_DAC_TIMING = 3'h4;
  localparam logic [2:0] REG_ANALOG_PATH = 3'h5;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int PM_MODE_BIT = 0;
  localparam int PM_MIXED_BIT = 1;
  localparam int PM_SWRST_BIT = 7;
  localparam int CR_RATE_LSB = 0;
  localparam int CR_SHIFT_LSB = 2;
  localparam int CR_MDIV_LSB = 4;
  localparam int PW_GLOBAL_BIT = 0;
  localparam int PW_ADC_BIT = 3;
  localparam int PW_DAC_BIT = 4;
  localparam int PW_REF_BIT = 5;
  localparam int DT_ADV_LSB = 0;
  localparam int DT_ADV_W = 5;
  // ----------------------------------------
  // Control word layout
  // ----------------------------------------
  localparam int WORD_W = 16;
  localparam int CW_CTRL_BIT = 15;
  localparam int CW_READ_BIT = 14;
  localparam int CW_DEV_LSB = 11;
  localparam int CW_REG_LSB = 8;
  // ----------------------------------------
  // Divider and timing constants
  // ----------------------------------------
  localparam logic [2:0] MDIV_CODES = 3'h5;
  localparam logic [3:0] SC_MAX_DIV = 4'h8;
  localparam int SR_MIN_DIV = 256;
  localparam logic [10:0] ADV_STEP = 11'h008;
  localparam logic [2:0] SWRST_CYCLES = 3'h4;
  localparam int FIRST_FS_DIVIDED_MASTER_CLOCK = 2048;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef logic [REG_COUNT-1:0][7:0] ctrl_bank_t;
  typedef struct packed {
    logic ref_on;
    logic dac_on;
    logic adc_on;
  } power_s;
  typedef struct packed {
    ctrl_bank_t ctrl;
    logic [2:0] mdiv_cnt;
    logic [2:0] sdiv_cnt;
    logic [10:0] smp_cnt;
    logic [15:0] rx_sr;
    logic [3:0] rx_cnt;
    logic rx_act;
    logic [15:0] tx_sr;
    logic [4:0] tx_cnt;
    logic tx_act;
    logic ofs;
    logic [15:0] dac_bank;
    logic [15:0] adc_bank;
    logic [15:0] dac_out;
    logic dac_load;
    logic [2:0] swrst_cnt;
  } core_s;
endpackage : codec_ctrl_pkg

// ===== verilog/codec_serial_control_regs.sv
// Codec serial port control registers, dividers and sample FIFO

// ----------------------------------------
// Sample FIFO
// ----------------------------------------
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("sample_fifo depth must be a power of two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_s;

  fifo_s s_q;
  fifo_s s_d;
  logic push;
  logic pop;

  assign in_ready = s_q.cnt != (AW+1)'(DEPTH);
  assign out_valid = s_q.cnt != '0;
  assign out_data = s_q.mem[s_q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = s_q.wp + 1'b1;
    end
    if (pop)
      s_d.rp = s_q.rp + 1'b1;
    if (push && !pop)
      s_d.cnt = s_q.cnt + 1'b1;
    else if (pop && !push)
      s_d.cnt = s_q.cnt - 1'b1;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      s_q <= '0;
    else
      s_q <= s_d;
  end
endmodule : sample_fifo

// ----------------------------------------
// Control block
// ----------------------------------------
module codec_serial_control_regs
  import codec_ctrl_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Serial port
  input wire logic serial_in,
  input wire logic input_frame_sync,
  output logic serial_out,
  output logic output_frame_sync,
  output logic shift_strobe,
  output logic divided_master_clock,
  // ADC sample stream
  input wire logic [WORD_W-1:0] adc_data,
  input wire logic adc_valid,
  output logic adc_ready,
  // DAC sample
  output logic [WORD_W-1:0] dac_sample,
  output logic dac_load,
  // Status
  output ctrl_bank_t ctrl_regs,
  output power_s power,
  output logic reset_busy
);
  // ----------------------------------------
  // Divider decode
  // ----------------------------------------
  function automatic logic [2:0] mdiv_last(input logic [2:0] sel);
    mdiv_last = (sel < MDIV_CODES) ? sel : '0;
  endfunction : mdiv_last

  function automatic logic [2:0] sdiv_last(input logic [1:0] sel);
    sdiv_last = 3'((SC_MAX_DIV >> sel) - 4'h1);
  endfunction : sdiv_last

  function automatic logic [10:0] smp_last(input logic [1:0] sel);
    smp_last = 11'((12'(SR_MIN_DIV) << (~sel)) - 12'h001);
  endfunction : smp_last

  core_s s_q;
  core_s s_d;
  logic [2:0] md_sel;
  logic [1:0] sc_sel;
  logic [1:0] sr_sel;
  logic [DT_ADV_W-1:0] adv;
  logic tick;
  logic shift_tk;
  logic smp_evt;
  logic [10:0] load_pos;
  logic rx_take;
  logic [15:0] rx_word;
  logic word_done;
  logic busy;
  logic mode_data;
  logic mixed;
  logic is_ctrl;
  logic is_data;
  logic [2:0] dev;
  logic [2:0] ridx;
  logic [7:0] rdata;
  logic ctrl_act;
  logic wr_req;
  logic rd_req;
  logic fwd_req;
  logic sw_req;
  logic [15:0] reply;
  logic fifo_valid;
  logic [WORD_W-1:0] fifo_data;
  logic [15:0] next_adc;

  sample_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .in_data(adc_data),
    .in_valid(adc_valid),
    .in_ready(adc_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(smp_evt)
  );

  // ----------------------------------------
  // Clock, shift and sample timing
  // ----------------------------------------
  assign md_sel = s_q.ctrl[REG_CLOCK_RATE][CR_MDIV_LSB +: 3];
  assign sc_sel = s_q.ctrl[REG_CLOCK_RATE][CR_SHIFT_LSB +: 2];
  assign sr_sel = s_q.ctrl[REG_CLOCK_RATE][CR_RATE_LSB +: 2];
  assign adv = s_q.ctrl[REG_DAC_TIMING][DT_ADV_LSB +: DT_ADV_W];
  assign tick = s_q.mdiv_cnt >= mdiv_last(md_sel);
  assign shift_tk = tick && (s_q.sdiv_cnt >= sdiv_last(sc_sel));
  assign smp_evt = tick && (s_q.smp_cnt >= smp_last(sr_sel));
  // Load point one shift period plus advance before the sample event
  assign load_pos = (smp_last(sr_sel) - 11'(sdiv_last(sc_sel)) - 11'h001
    - 11'(adv) * ADV_STEP) & smp_last(sr_sel);

  // ----------------------------------------
  // Word decode
  // ----------------------------------------
  assign rx_take = shift_tk && (s_q.rx_act || input_frame_sync);
  assign rx_word = {s_q.rx_sr[14:0], serial_in};
  assign word_done = rx_take && s_q.rx_act && (s_q.rx_cnt == 4'hF);
  assign busy = s_q.swrst_cnt != '0;
  assign mode_data = s_q.ctrl[REG_PORT_MODE][PM_MODE_BIT];
  assign mixed = s_q.ctrl[REG_PORT_MODE][PM_MIXED_BIT];
  // Program mode takes only control words
  assign is_ctrl = rx_word[CW_CTRL_BIT] && (!mode_data || mixed);
  assign is_data = mode_data && (!mixed || !rx_word[CW_CTRL_BIT]);
  assign dev = rx_word[CW_DEV_LSB +: 3];
  assign ridx = rx_word[CW_REG_LSB +: 3];
  assign rdata = (ridx < REG_COUNT) ? s_q.ctrl[ridx] : '0;
  assign ctrl_act = word_done && !busy && is_ctrl;
  assign wr_req = ctrl_act && dev == '0 && !rx_word[CW_READ_BIT]
    && ridx < REG_COUNT;
  assign rd_req = ctrl_act && dev == '0 && rx_word[CW_READ_BIT];
  assign fwd_req = ctrl_act && dev != '0;
  assign sw_req = wr_req && ridx == REG_PORT_MODE
    && rx_word[PM_SWRST_BIT];
  assign reply = rd_req ? {rx_word[15:8], rdata}
    : {rx_word[15:14], dev - 3'h1, rx_word[10:0]};
  assign next_adc = fifo_valid ? fifo_data : s_q.adc_bank;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.dac_load = 1'b0;
    s_d.mdiv_cnt = tick ? '0 : s_q.mdiv_cnt + 3'h1;
    if (tick) begin
      s_d.sdiv_cnt = shift_tk ? '0 : s_q.sdiv_cnt + 3'h1;
      s_d.smp_cnt = smp_evt ? '0 : s_q.smp_cnt + 11'h001;
      if (s_q.smp_cnt == load_pos) begin
        s_d.dac_load = 1'b1;
        s_d.dac_out = s_q.dac_bank;
      end
      if (busy)
        s_d.swrst_cnt = s_q.swrst_cnt - 3'h1;
    end
    // Receive on shift clock falling edge
    if (rx_take) begin
      s_d.rx_sr = rx_word;
      s_d.rx_act = !word_done;
      s_d.rx_cnt = s_q.rx_act ? s_q.rx_cnt + 4'h1 : 4'h1;
    end
    if (word_done && !busy && is_data)
      s_d.dac_bank = mixed ? {rx_word[14:0], 1'b0} : rx_word;
    if (wr_req)
      s_d.ctrl[ridx] = rx_word[7:0];
    if (sw_req) begin
      s_d.swrst_cnt = SWRST_CYCLES;
    end
    // Registers held cleared while a reset runs
    if (sw_req || busy)
      s_d.ctrl = {REG_COUNT{REG_RESET_VAL}};
    // Transmit, most significant bit first
    if (s_q.tx_act && shift_tk) begin
      s_d.ofs = 1'b0;
      s_d.tx_sr = {s_q.tx_sr[14:0], 1'b0};
      s_d.tx_cnt = s_q.tx_cnt - 5'h01;
      if (s_q.tx_cnt == 5'h01)
        s_d.tx_act = 1'b0;
    end
    if (smp_evt) begin
      s_d.adc_bank = next_adc;
      s_d.tx_sr = next_adc;
      s_d.tx_cnt = 5'(WORD_W);
      s_d.tx_act = 1'b1;
      s_d.ofs = 1'b1;
    end else if ((rd_req || fwd_req) && !s_q.tx_act) begin
      s_d.tx_sr = reply;
      s_d.tx_cnt = 5'(WORD_W);
      s_d.tx_act = 1'b1;
      s_d.ofs = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign serial_out = s_q.tx_sr[WORD_W-1];
  assign output_frame_sync = s_q.ofs;
  assign shift_strobe = shift_tk;
  assign divided_master_clock = tick;
  assign dac_sample = s_q.dac_out;
  assign dac_load = s_q.dac_load;
  assign ctrl_regs = s_q.ctrl;
  assign reset_busy = busy;
  // Own bit or global bit powers a section
  assign power.adc_on = s_q.ctrl[REG_POWER][PW_ADC_BIT]
    | s_q.ctrl[REG_POWER][PW_GLOBAL_BIT];
  assign power.dac_on = s_q.ctrl[REG_POWER][PW_DAC_BIT]
    | s_q.ctrl[REG_POWER][PW_GLOBAL_BIT];
  assign power.ref_on = s_q.ctrl[REG_POWER][PW_REF_BIT]
    | s_q.ctrl[REG_POWER][PW_GLOBAL_BIT];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic seen_q;
  logic [11:0] first_cnt_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      seen_q <= 1'b0;
      first_cnt_q <= '0;
    end else begin
      if (s_q.ofs)
        seen_q <= 1'b1;
      if (tick && !seen_q)
        first_cnt_q <= first_cnt_q + 12'h001;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_sw_reset;
    sw_req |=> s_q.ctrl == '0 && busy;
  endproperty
  a_sw_reset: assert property (p_sw_reset)
    else $error("software reset did not clear registers");

  property p_reset_len;
    $rose(busy) |-> ##[1:20] !busy;
  endproperty
  a_reset_len: assert property (p_reset_len)
    else $error("software reset too long");

  property p_pgm_mode;
    busy |-> !s_q.ctrl[REG_PORT_MODE][PM_MODE_BIT];
  endproperty
  a_pgm_mode: assert property (p_pgm_mode)
    else $error("mode bit set during reset");

  property p_first_fs;
    $rose(output_frame_sync) && !seen_q && sr_sel == '0
      |-> first_cnt_q == 12'(FIRST_FS_DIVIDED_MASTER_CLOCK);
  endproperty
  a_first_fs: assert property (p_first_fs)
    else $error("first frame sync at wrong time");

  property p_power_keep;
    $fell(s_q.ctrl[REG_POWER][PW_GLOBAL_BIT])
      && s_q.ctrl[REG_POWER][PW_REF_BIT] |-> power.ref_on;
  endproperty
  a_power_keep: assert property (p_power_keep)
    else $error("reference lost power");

  property p_write;
    wr_req && !sw_req |=> s_q.ctrl[$past(ridx)] == $past(rx_word[7:0]);
  endproperty
  a_write: assert property (p_write)
    else $error("register write lost");

  property p_read;
    rd_req && !smp_evt && !s_q.tx_act && ridx >= REG_COUNT
      |=> s_q.tx_sr[7:0] == '0 && s_q.ofs;
  endproperty
  a_read: assert property (p_read)
    else $error("reserved read not zero");

  property p_fwd;
    fwd_req && !smp_evt && !s_q.tx_act
      |=> s_q.tx_sr[13:11] == $past(dev) - 3'h1 ##1 s_q.tx_act;
  endproperty
  a_fwd: assert property (p_fwd)
    else $error("forwarded address not decremented");

  property p_mdiv5;
    tick && md_sel == MDIV_CODES - 3'h1 && !wr_req |=> !tick [*4] ##1 tick;
  endproperty
  a_mdiv5: assert property (p_mdiv5)
    else $error("divide by five wrong");

  property p_dac_lead;
    s_q.dac_load && md_sel == '0 && sc_sel == '0 && adv == '0
      && !s_q.tx_act |-> ##8 $rose(output_frame_sync);
  endproperty
  a_dac_lead: assert property (p_dac_lead)
    else $error("DAC load not one shift period early");

  property p_msb;
    smp_evt |=> serial_out == $past(next_adc[WORD_W-1]);
  endproperty
  a_msb: assert property (p_msb)
    else $error("first bit is not the MSB");

  property p_cov_write;
    wr_req;
  endproperty
  c_cov_write: cover property (p_cov_write);

  property p_cov_fwd;
    fwd_req ##1 s_q.tx_act;
  endproperty
  c_cov_fwd: cover property (p_cov_fwd);

  property p_cov_sample;
    smp_evt && fifo_valid;
  endproperty
  c_cov_sample: cover property (p_cov_sample);
endmodule : codec_serial_control_regs

// ===== tb/host_serial_model.sv
// Host serial port model for the codec control bench
module host_serial_model (
  // Clock
  input wire logic core_clk,
  // From codec
  input wire logic shift_strobe,
  input wire logic serial_out,
  input wire logic output_frame_sync,
  // To codec
  output logic serial_in,
  output logic input_frame_sync
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] tx_q[$];
  logic [15:0] rx_q[$];
  logic [15:0] cur;
  logic [15:0] rxw;
  int idx = -1;
  int rxn = 0;
  bit pend = 1'h0;
  initial begin
    serial_in = 1'h0;
    input_frame_sync = 1'h0;
  end
  function automatic bit busy();
    return idx >= 0 || tx_q.size() > 0;
  endfunction : busy
  function automatic logic [15:0] head();
    return rx_q.size() > 0 ? rx_q[0] : 16'hxxxx;
  endfunction : head
  // ------
  // Send side, idle line inverted
  // ------
  always @(negedge core_clk) begin
    if (pend) begin
      input_frame_sync = 1'h0;
      idx--;
      serial_in = idx >= 0 ? cur[idx] : ~serial_in;
    end
    pend = 1'h0;
    if (shift_strobe === 1'h1) begin
      if (idx < 0 && tx_q.size() > 0) begin
        cur = tx_q.pop_front();
        idx = 15;
        serial_in = cur[15];
        input_frame_sync = 1'h1;
      end
      pend = idx >= 0;
    end
  end
  // ------
  // Receive side
  // ------
  always @(posedge core_clk) begin
    if (shift_strobe === 1'h1) begin
      if (output_frame_sync === 1'h1) begin
        rxw = {15'h0000, serial_out};
        rxn = 1;
      end else if (rxn > 0) begin
        rxw = {rxw[14:0], serial_out};
        rxn++;
      end
      if (rxn == 16) begin
        rx_q.push_back(rxw);
        rxn = 0;
      end
    end
  end
endmodule : host_serial_model

// ===== tb/testbench.sv
// Self-checking bench for the codec serial control block
module testbench
  import codec_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'h0;
  logic rstn = 1'h0;
  logic adc_valid = 1'h0;
  logic [WORD_W-1:0] adc_data = 16'h0000;
  logic serial_in, input_frame_sync, serial_out, output_frame_sync;
  logic shift_strobe, divided_master_clock, adc_ready, dac_load;
  logic reset_busy, ofs_p;
  logic [WORD_W-1:0] dac_sample;
  ctrl_bank_t ctrl_regs;
  power_s power;
  int error_cnt = 0;
  int checks = 0;
  logic [7:0] vals [8] = '{8'h00, 8'h0F, 8'h58, 8'hA5, 8'h1F, 8'hE0,
    8'h77, 8'h88};
  logic [7:0] pw_in [5] = '{8'h00, 8'h08, 8'h10, 8'h21, 8'h20};
  logic [2:0] pw_exp [5] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h4};
  logic [4:0] adv_v [4] = '{5'h00, 5'h1F, 5'h00, 5'h05};
  logic [1:0] adv_s [4] = '{2'h0, 2'h0, 2'h3, 2'h2};

  always #25 core_clk = ~core_clk;
  always @(negedge core_clk) ofs_p <= output_frame_sync;

  codec_serial_control_regs #(.FIFO_DEPTH(16)) i_codec_serial_control_regs (
    .core_clk(core_clk), .rstn(rstn), .serial_in(serial_in),
    .input_frame_sync(input_frame_sync), .serial_out(serial_out),
    .output_frame_sync(output_frame_sync), .shift_strobe(shift_strobe),
    .divided_master_clock(divided_master_clock), .adc_data(adc_data),
    .adc_valid(adc_valid), .adc_ready(adc_ready), .dac_sample(dac_sample),
    .dac_load(dac_load), .ctrl_regs(ctrl_regs), .power(power),
    .reset_busy(reset_busy));

  host_serial_model i_host_serial_model (.core_clk(core_clk),
    .shift_strobe(shift_strobe), .serial_out(serial_out),
    .output_frame_sync(output_frame_sync), .serial_in(serial_in),
    .input_frame_sync(input_frame_sync));

  // ------
  // Helpers
  // ------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("Counts: %0d checks, %0d errors", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic done(input string s);
    $display("Test %s ended, errors so far %0d", s, error_cnt);
  endtask : done
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  function automatic logic ev(input int w);
    case (w)
      0: return divided_master_clock;
      1: return shift_strobe;
      2: return output_frame_sync & ~ofs_p;
      3: return dac_load;
      default: return 1'h1;
    endcase
  endfunction : ev
  task automatic gap(input int a, input int b, output int n);
    n = 0;
    while (!ev(a) && n < 5000) begin
      cyc(1);
      n++;
    end
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (!ev(b) && n < 5000);
  endtask : gap
  task automatic rx_wait(input int k);
    int t;
    t = 0;
    while (i_host_serial_model.rx_q.size() < k && t < 6000) begin
      cyc(1);
      t++;
    end
  endtask : rx_wait
  task automatic send(input logic [15:0] w);
    int t;
    t = 0;
    i_host_serial_model.tx_q.push_back(w);
    while (i_host_serial_model.busy() && t < 2000) begin
      cyc(1);
      t++;
    end
    cyc(2);
  endtask : send
  task automatic wr(input logic [2:0] r, input logic [7:0] d);
    send({5'h10, r, d});
  endtask : wr
  task automatic xfer(input logic [15:0] w, input logic [15:0] e);
    i_host_serial_model.rx_q.delete();
    rx_wait(1);
    i_host_serial_model.rx_q.delete(); // Drop sample word
    send(w);
    rx_wait(1);
    chk(i_host_serial_model.head(), e);
  endtask : xfer
  task automatic hw_reset();
    int n;
    rstn = 1'h0;
    cyc(3);
    for (int i = 0; i < 6; i++)
      chk(ctrl_regs[i], REG_RESET_VAL);
    chk(ctrl_regs[0][PM_MODE_BIT], 16'h0000);
    rstn = 1'h1;
    gap(9, 2, n);
    chk(16'(n), 16'(FIRST_FS_DIVIDED_MASTER_CLOCK));
  endtask : hw_reset

  // ------
  // Tests
  // ------
  initial begin
    int n;
    hw_reset();
    done("reset");
    for (int r = 7; r >= 0; r--)
      wr(3'(r), vals[r]); // Advance before power
    for (int r = 0; r < 6; r++)
      chk(ctrl_regs[r], vals[r]);
    for (int r = 0; r < 6; r++)
      xfer({5'h18, 3'(r), 8'h00}, {5'h18, 3'(r), vals[r]});
    for (int r = 6; r < 8; r++)
      xfer({5'h18, 3'(r), 8'h00}, {5'h18, 3'(r), 8'h00});
    xfer(16'h8A33, 16'h8233);
    xfer(16'hBA33, 16'hB233);
    chk(ctrl_regs[2], vals[2]);
    send(16'h0233);
    chk(ctrl_regs[2], vals[2]);
    done("registers");
    foreach (pw_in[i]) begin
      wr(REG_POWER, pw_in[i]);
      chk(power, pw_exp[i]);
    end
    done("power");
    for (int c = 0; c < 8; c++) begin
      wr(REG_CLOCK_RATE, {1'h0, 3'(c), 4'hC});
      gap(0, 0, n);
      chk(16'(n), c < MDIV_CODES ? 16'(c + 1) : 16'h0001);
    end
    for (int s = 0; s < 4; s++) begin
      wr(REG_CLOCK_RATE, {4'h0, 2'(s), 2'h0});
      gap(1, 1, n);
      chk(16'(n), 16'(SC_MAX_DIV >> s));
    end
    for (int d = 0; d < 4; d++) begin
      wr(REG_CLOCK_RATE, {6'h03, 2'(d)});
      gap(2, 2, n);
      chk(16'(n), 16'(SR_MIN_DIV << (3 - d)));
    end
    done("dividers");
    for (int k = 0; k < 4; k++) begin
      wr(REG_CLOCK_RATE, {4'h0, adv_s[k], 2'h0});
      wr(REG_DAC_TIMING, {3'h0, adv_v[k]});
      gap(3, 2, n);
      chk(16'(n), 16'((SC_MAX_DIV >> adv_s[k]) + adv_v[k] * ADV_STEP));
    end
    done("dac advance");
    wr(REG_PORT_MODE, 8'h03);
    send(16'h1234);
    gap(9, 3, n);
    chk(dac_sample, 16'h2468);
    done("mixed mode");
    wr(REG_CLOCK_RATE, 8'h0F);
    i_host_serial_model.rx_q.delete();
    rx_wait(1);
    n = 0;
    while (adc_ready === 1'h1 && n < 20) begin
      adc_data = 16'hA000 + 16'(n);
      adc_valid = 1'h1;
      cyc(1);
      n++;
    end
    adc_valid = 1'h0;
    chk(16'(n), 16'h0010);
    i_host_serial_model.rx_q.delete();
    rx_wait(17);
    for (int i = 0; i < 17; i++)
      chk(i_host_serial_model.rx_q[i], 16'hA000 + 16'(i < 16 ? i : 15));
    done("sample fifo");
    i_host_serial_model.tx_q.push_back(16'h8080);
    n = 0;
    repeat (300) begin
      cyc(1);
      if (reset_busy === 1'h1)
        n++;
    end
    chk(16'(n >= 1 && n <= SWRST_CYCLES), 16'h0001);
    for (int r = 0; r < 6; r++)
      chk(ctrl_regs[r], REG_RESET_VAL);
    chk(ctrl_regs[0][PM_MODE_BIT], 16'h0000);
    done("software reset");
    wr(REG_GAIN, 8'hA5);
    wr(REG_PORT_MODE, 8'h01);
    send(16'h8355);
    gap(9, 3, n);
    chk(dac_sample, 16'h8355);
    chk(ctrl_regs[REG_GAIN], 8'hA5);
    done("data mode");
    hw_reset();
    done("second reset");
    conclude();
  end

  initial begin
    repeat (100000) @(negedge core_clk);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end
endmodule : testbench
